// ===== fault_diagnostic_reporter.sv
// Fault flags, confirmation timers, occurrence counts and DM1 scheduling.
// Assumes an APB master, sample values and link handshakes on clk.
//
// Function
// - Clearing a low or high threshold fault applies a configurable hysteresis band.
// - Per block, a generate setting decides whether active codes are reported.
// - With any block generating, DM1 goes out every second, faults or not.
// - With no active codes, the periodic DM1 says no faults active.
// - A code turning active sends a DM1 at once.
// - The last active code going inactive sends a DM1 at once.
// - More than one active code sends DM1 as multipacket transport.
// - A new fault must last the confirm delay; then active, count up, send.
// - Occurrence counts are kept in storage that survives power loss.
// - By default a cleared fault makes its code previously active.
// - With latching, the code stays active until a DM11 clear request finds the fault gone.
// - Lamp byte uses the selected lamp: protect, amber, red, malfunction.
// - A block with zero suspect parameter number never reports.
// - Changing the suspect parameter number resets its occurrence count.
// - Each fault has a default failure mode; valid codes are 0-21 and 31.
// - A low-fault failure mode gives the high fault its paired code.
// - Any other failure mode is reported for both low and high faults.
// - A receive message missing past its timeout raises lost communication.
// - Supply faults flag below undervoltage and above overvoltage thresholds.
`timescale 1ns/1ps
module fault_diagnostic_reporter #(
    parameter int TICK_CYCLES = fdr_pkg::TICK_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [fdr_pkg::VW-1:0]   sample_value [fdr_pkg::NB],
    input  wire logic                     rx_seen,
    input  wire logic                     dm1_ack,
    output logic                          dm1_req,
    output logic                          dm1_multi,
    output logic      [2:0]               dm1_count,
    output logic      [fdr_pkg::NB-1:0]   dm1_mask,
    output logic      [7:0]               dm1_lamp,
    input  wire logic [1:0]               dtc_sel,
    output logic      [fdr_pkg::SW-1:0]   dtc_spn,
    output logic      [fdr_pkg::FW-1:0]   dtc_fmi,
    output logic      [fdr_pkg::OW-1:0]   dtc_oc,
    input  wire logic                     nv_load,
    input  wire logic [1:0]               nv_load_idx,
    input  wire logic [fdr_pkg::OW-1:0]   nv_load_count,
    output logic                          nv_store,
    output logic      [1:0]               nv_store_idx,
    output logic      [fdr_pkg::OW-1:0]   nv_store_count
);
    import fdr_pkg::*;

    logic [1:0]    rsync_r;
    logic          rst_n;
    logic [16:0]   div_r, div_nxt;
    logic          tick;
    logic [CW-1:0] cfg_r [NB], cfg_nxt [NB];
    logic [SW-1:0] spn_r [NB], spn_nxt [NB];
    logic [VW-1:0] low_r [NB], low_nxt [NB];
    logic [VW-1:0] high_r [NB], high_nxt [NB];
    logic [VW-1:0] band_r [NB], band_nxt [NB];
    logic [VW-1:0] dly_r [NB], dly_nxt [NB];
    logic [VW-1:0] cnt_r [NB], cnt_nxt [NB];
    logic [OW-1:0] occ_r [NB], occ_nxt [NB];
    logic [NB-1:0] flag_r, flag_nxt, hi_r, hi_nxt, act_r, act_nxt;
    logic [NB-1:0] prev_r, prev_nxt, pend_r, pend_nxt, dirty_r, dirty_nxt;
    logic [NB-1:0] rep_r, rep_nxt;
    logic [VW-1:0] rxto_r, rxto_nxt, rxcnt_r, rxcnt_nxt;
    logic [9:0]    sec_r, sec_nxt;
    logic          spend_r, spend_nxt;
    dm1_state_t    st_r, st_nxt;
    logic          multi_nxt;
    logic [2:0]    count_nxt;
    logic [NB-1:0] mask_nxt;
    logic [7:0]    lamp_nxt;
    logic [31:0]   prdata_nxt;
    logic          err_r, err_nxt;
    logic          nvs_nxt;
    logic [1:0]    nvi_nxt;
    logic [OW-1:0] nvc_nxt;
    logic [SW-1:0] dspn_nxt;
    logic [FW-1:0] dfmi_nxt;
    logic [OW-1:0] doc_nxt;
    logic          setup, wr, ingl, inblk, dm11, rx_lost, per_evt, any_gen;
    logic [1:0]    bidx;
    logic [2:0]    bsel;
    logic [VW-1:0] hclr;
    logic [VW:0]   lclr;

    // Reset is released through two flip-flops so that its removal is synchronous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsync_r <= 2'b00;
        end else begin
            rsync_r <= {rsync_r[0], 1'b1};
        end
    end
    assign rst_n = rsync_r[1];

    assign tick    = (div_r == 17'(TICK_CYCLES - 1));
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite && !err_r;
    assign bsel    = paddr[7:5] - B_FIRST;
    assign bidx    = bsel[1:0];
    assign inblk   = (paddr[11:8] == 4'h0) && (paddr[7:5] >= B_FIRST) && (paddr[7:5] <= B_LAST)
                     && (paddr[4:0] <= F_STAT) && (paddr[1:0] == 2'b00);
    assign ingl    = (paddr == A_CTRL) || (paddr == A_RXTO) || (paddr == A_DM1);
    assign dm11    = wr && (paddr == A_CTRL) && pwdata[0];
    assign rx_lost = (rxto_r != '0) && (rxcnt_r >= rxto_r);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_r;
    assign dm1_req = (st_r == S_SEND);

    always_comb begin
        div_nxt   = tick ? '0 : div_r + 17'h1;
        rxto_nxt  = rxto_r;
        rxcnt_nxt = rxcnt_r;
        if (rx_seen) begin
            rxcnt_nxt = '0;
        end else if (tick && (rxcnt_r != 16'hffff)) begin
            rxcnt_nxt = rxcnt_r + 16'h1;
        end
        if (wr && (paddr == A_RXTO)) begin
            rxto_nxt = pwdata[VW-1:0];
        end
        flag_nxt  = flag_r;
        hi_nxt    = hi_r;
        act_nxt   = act_r;
        prev_nxt  = prev_r;
        pend_nxt  = pend_r;
        dirty_nxt = dirty_r;
        hclr      = '0;
        lclr      = '0;
        // One count leaves per cycle; lowest dirty block first
        nvs_nxt = 1'b0;
        nvi_nxt = 2'h0;
        nvc_nxt = '0;
        for (int b = NB - 1; b >= 0; b--) begin
            if (dirty_r[b]) begin
                nvs_nxt = 1'b1;
                nvi_nxt = 2'(b);
            end
        end
        nvc_nxt = occ_r[nvi_nxt];
        if (nvs_nxt) begin
            dirty_nxt[nvi_nxt] = 1'b0;
        end
        for (int b = 0; b < NB; b++) begin
            cfg_nxt[b]  = cfg_r[b];
            spn_nxt[b]  = spn_r[b];
            low_nxt[b]  = low_r[b];
            high_nxt[b] = high_r[b];
            band_nxt[b] = band_r[b];
            dly_nxt[b]  = dly_r[b];
            cnt_nxt[b]  = cnt_r[b];
            occ_nxt[b]  = occ_r[b];
            hclr = (high_r[b] > band_r[b]) ? high_r[b] - band_r[b] : '0;
            lclr = {1'b0, low_r[b]} + {1'b0, band_r[b]};
            if (b == COMM) begin
                flag_nxt[b] = rx_lost;
                hi_nxt[b]   = 1'b1;
            end else if (!flag_r[b]) begin
                if (sample_value[b] > high_r[b]) begin
                    flag_nxt[b] = 1'b1;
                    hi_nxt[b]   = 1'b1;
                end else if (sample_value[b] < low_r[b]) begin
                    flag_nxt[b] = 1'b1;
                    hi_nxt[b]   = 1'b0;
                end
            end else if (hi_r[b]) begin
                if (sample_value[b] <= hclr) begin
                    flag_nxt[b] = 1'b0;
                end
            end else if ({1'b0, sample_value[b]} >= lclr) begin
                flag_nxt[b] = 1'b0;
            end
            if (flag_nxt[b] && !act_r[b] && !pend_r[b]) begin
                pend_nxt[b] = 1'b1;
                cnt_nxt[b]  = dly_r[b];
            end else if (pend_r[b]) begin
                if (!flag_nxt[b]) begin
                    pend_nxt[b] = 1'b0;
                end else if (cnt_r[b] == '0) begin
                    pend_nxt[b] = 1'b0;
                    act_nxt[b]  = 1'b1;
                    prev_nxt[b] = 1'b0;
                    if (occ_r[b] != '1) begin
                        occ_nxt[b] = occ_r[b] + 7'h1;
                    end
                    dirty_nxt[b] = 1'b1;
                end else if (tick) begin
                    cnt_nxt[b] = cnt_r[b] - 16'h1;
                end
            end
            // A still-present fault survives a clear request; only gone faults retire
            if (act_r[b] && !flag_r[b] && (!cfg_r[b][C_LATCH] || dm11)) begin
                act_nxt[b]  = 1'b0;
                prev_nxt[b] = 1'b1;
            end
            if (nv_load && (nv_load_idx == 2'(b))) begin
                occ_nxt[b] = nv_load_count;
            end
            if (wr && inblk && (bidx == 2'(b))) begin
                case (paddr[4:0])
                    F_CFG: begin
                        cfg_nxt[b][C_FMI-1:0] = pwdata[C_FMI-1:0];
                        if (fmi_valid(pwdata[C_FMI+FW-1:C_FMI])) begin
                            cfg_nxt[b][CW-1:C_FMI] = pwdata[C_FMI+FW-1:C_FMI];
                        end
                    end
                    F_SPN: begin
                        spn_nxt[b] = pwdata[SW-1:0];
                        if (pwdata[SW-1:0] != spn_r[b]) begin
                            occ_nxt[b]   = '0;
                            dirty_nxt[b] = 1'b1;
                        end
                    end
                    F_LOW:   low_nxt[b]  = pwdata[VW-1:0];
                    F_HIGH:  high_nxt[b] = pwdata[VW-1:0];
                    F_BAND:  band_nxt[b] = pwdata[VW-1:0];
                    F_DLY:   dly_nxt[b]  = pwdata[VW-1:0];
                    default: ;
                endcase
            end
            rep_nxt[b] = act_nxt[b] && cfg_nxt[b][C_GEN] && (spn_nxt[b] != '0);
        end
        any_gen = 1'b0;
        for (int b = 0; b < NB; b++) begin
            any_gen = any_gen | cfg_r[b][C_GEN];
        end
        per_evt = 1'b0;
        sec_nxt = sec_r;
        if (!any_gen) begin
            sec_nxt = '0;
        end else if (tick) begin
            if (sec_r == 10'(DM1_PERIOD_MS - 1)) begin
                sec_nxt = '0;
                per_evt = 1'b1;
            end else begin
                sec_nxt = sec_r + 10'h1;
            end
        end
        st_nxt    = st_r;
        spend_nxt = spend_r;
        multi_nxt = dm1_multi;
        count_nxt = dm1_count;
        mask_nxt  = dm1_mask;
        lamp_nxt  = dm1_lamp;
        case (st_r)
            S_IDLE: begin
                if (spend_r) begin
                    spend_nxt = 1'b0;
                    st_nxt    = S_LOAD;
                end
            end
            S_LOAD: begin
                mask_nxt  = rep_r;
                count_nxt = '0;
                lamp_nxt  = '0;
                for (int b = 0; b < NB; b++) begin
                    if (rep_r[b]) begin
                        count_nxt = count_nxt + 3'h1;
                        lamp_nxt[{cfg_r[b][C_LAMP+1:C_LAMP], 1'b0}] = 1'b1;
                    end
                end
                multi_nxt = (count_nxt > 3'h1);
                st_nxt    = S_SEND;
            end
            S_SEND: begin
                if (dm1_ack) begin
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
        // A new event in the launch cycle re-arms the request instead of being lost
        if (((rep_nxt & ~rep_r) != '0) || ((rep_r != '0) && (rep_nxt == '0)) || per_evt) begin
            spend_nxt = 1'b1;
        end
        dspn_nxt = spn_r[dtc_sel];
        dfmi_nxt = fmi_report(cfg_r[dtc_sel][CW-1:C_FMI], hi_r[dtc_sel]);
        doc_nxt  = occ_r[dtc_sel];
        prdata_nxt = prdata;
        err_nxt    = err_r;
        if (setup) begin
            err_nxt    = !(ingl || inblk);
            prdata_nxt = '0;
            if (paddr == A_RXTO) begin
                prdata_nxt[VW-1:0] = rxto_r;
            end else if (paddr == A_DM1) begin
                prdata_nxt = {10'h0, st_r, dm1_lamp, dm1_mask, dm1_multi, dm1_count, rep_r};
            end else if (inblk) begin
                case (paddr[4:0])
                    F_CFG:  prdata_nxt[CW-1:0] = cfg_r[bidx];
                    F_SPN:  prdata_nxt[SW-1:0] = spn_r[bidx];
                    F_LOW:  prdata_nxt[VW-1:0] = low_r[bidx];
                    F_HIGH: prdata_nxt[VW-1:0] = high_r[bidx];
                    F_BAND: prdata_nxt[VW-1:0] = band_r[bidx];
                    F_DLY:  prdata_nxt[VW-1:0] = dly_r[bidx];
                    F_STAT: prdata_nxt[24:0] = {occ_r[bidx], cnt_r[bidx][6:0],
                                fmi_report(cfg_r[bidx][CW-1:C_FMI], hi_r[bidx]), rep_r[bidx],
                                pend_r[bidx], prev_r[bidx], act_r[bidx], hi_r[bidx], flag_r[bidx]};
                    default: prdata_nxt = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r   <= '0;
            rxto_r  <= RXTO_RST;
            rxcnt_r <= '0;
            for (int b = 0; b < NB; b++) begin
                cfg_r[b]  <= {FMI_RST[b], LAMP_RST, 2'b00};
                spn_r[b]  <= SPN_RST;
                low_r[b]  <= LOW_RST;
                high_r[b] <= HIGH_RST;
                band_r[b] <= BAND_RST;
                dly_r[b]  <= DLY_RST;
                cnt_r[b]  <= '0;
                occ_r[b]  <= '0;
            end
            {flag_r, hi_r, act_r, prev_r} <= '0;
            {pend_r, dirty_r, rep_r}      <= '0;
            sec_r     <= '0;
            spend_r   <= 1'b0;
            st_r      <= S_IDLE;
            dm1_multi <= 1'b0;
            dm1_count <= '0;
            dm1_mask  <= '0;
            dm1_lamp  <= '0;
            prdata    <= '0;
            err_r     <= 1'b0;
            nv_store       <= 1'b0;
            nv_store_idx   <= '0;
            nv_store_count <= '0;
            dtc_spn <= '0;
            dtc_fmi <= '0;
            dtc_oc  <= '0;
        end else begin
            div_r   <= div_nxt;
            rxto_r  <= rxto_nxt;
            rxcnt_r <= rxcnt_nxt;
            cfg_r   <= cfg_nxt;
            spn_r   <= spn_nxt;
            low_r   <= low_nxt;
            high_r  <= high_nxt;
            band_r  <= band_nxt;
            dly_r   <= dly_nxt;
            cnt_r   <= cnt_nxt;
            occ_r   <= occ_nxt;
            {flag_r, hi_r, act_r, prev_r} <= {flag_nxt, hi_nxt, act_nxt, prev_nxt};
            {pend_r, dirty_r, rep_r}      <= {pend_nxt, dirty_nxt, rep_nxt};
            sec_r     <= sec_nxt;
            spend_r   <= spend_nxt;
            st_r      <= st_nxt;
            dm1_multi <= multi_nxt;
            dm1_count <= count_nxt;
            dm1_mask  <= mask_nxt;
            dm1_lamp  <= lamp_nxt;
            prdata    <= prdata_nxt;
            err_r     <= err_nxt;
            nv_store       <= nvs_nxt;
            nv_store_idx   <= nvi_nxt;
            nv_store_count <= nvc_nxt;
            dtc_spn <= dspn_nxt;
            dtc_fmi <= dfmi_nxt;
            dtc_oc  <= doc_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    hyst_hold_a: assert property (flag_r[1] && hi_r[1] && (high_r[1] > band_r[1]) &&
        (sample_value[1] > high_r[1] - band_r[1]) |=> flag_r[1]) else $error("flag cleared inside band");
    over_set_a: assert property (!flag_r[1] && (sample_value[1] > high_r[1]) |=> flag_r[1] && hi_r[1])
        else $error("overvoltage not flagged");
    confirm_need_a: assert property ($rose(act_r[0]) |-> $past(pend_r[0]) && $past(flag_r[0]))
        else $error("code active without confirmed fault");
    occ_step_a: assert property ($rose(act_r[0]) && !$past(wr) && !$past(nv_load) && ($past(occ_r[0]) != 7'h7f)
        |-> occ_r[0] == $past(occ_r[0]) + 7'h1) else $error("occurrence count not incremented");
    new_send_a: assert property ((rep_r & ~$past(rep_r)) != '0 |-> spend_r)
        else $error("new code did not request DM1");
    last_clear_a: assert property ($fell(|rep_r) |-> spend_r) else $error("all clear not sent");
    period_send_a: assert property (any_gen && tick && (sec_r == 10'(DM1_PERIOD_MS - 1)) |=> spend_r)
        else $error("periodic DM1 missing");
    multi_pack_a: assert property (dm1_req |-> dm1_multi == (dm1_count > 3'h1))
        else $error("transport choice wrong");
    no_fault_a: assert property (dm1_req && (dm1_count == 3'h0) |-> (dm1_lamp == 8'h00) && (dm1_mask == '0))
        else $error("empty DM1 carries content");
    zero_spn_a: assert property ((spn_r[0] == '0) |-> !rep_r[0]) else $error("zero parameter reported");
    spn_reset_a: assert property (wr && inblk && (bidx == 2'h0) && (paddr[4:0] == F_SPN) &&
        (pwdata[SW-1:0] != spn_r[0]) |=> occ_r[0] == '0) else $error("count kept after parameter change");
    latch_keep_a: assert property (act_r[0] && cfg_r[0][C_LATCH] && !dm11 |=> act_r[0])
        else $error("latched code dropped");
endmodule

// ===== fdr_pkg.sv
// Constants, types and helpers for the fault diagnostic reporter.
// Assumes a 100 MHz clock and an APB master with 32-bit data.
package fdr_pkg;
    localparam int NB            = 4;
    localparam int VW            = 16;
    localparam int SW            = 19;
    localparam int OW            = 7;
    localparam int FW            = 5;
    localparam int CW            = 9;
    localparam int COMM          = 3;
    localparam int CLK_NS        = 10;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYC      = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int DM1_PERIOD_MS = 1000;

    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_RXTO = 12'h004;
    localparam logic [11:0] A_DM1  = 12'h008;
    localparam logic [2:0]  B_FIRST = 3'h2;
    localparam logic [2:0]  B_LAST  = 3'h5;
    localparam logic [4:0]  F_CFG  = 5'h00;
    localparam logic [4:0]  F_SPN  = 5'h04;
    localparam logic [4:0]  F_LOW  = 5'h08;
    localparam logic [4:0]  F_HIGH = 5'h0c;
    localparam logic [4:0]  F_BAND = 5'h10;
    localparam logic [4:0]  F_DLY  = 5'h14;
    localparam logic [4:0]  F_STAT = 5'h18;

    localparam int C_GEN   = 0;
    localparam int C_LATCH = 1;
    localparam int C_LAMP  = 2;
    localparam int C_FMI   = 4;

    localparam logic [1:0]    LAMP_RST = 2'h1;
    localparam logic [FW-1:0] FMI_RST [NB] = '{5'h01, 5'h04, 5'h00, 5'h13};
    localparam logic [VW-1:0] LOW_RST  = 16'h0000;
    localparam logic [VW-1:0] HIGH_RST = 16'hffff;
    localparam logic [VW-1:0] BAND_RST = 16'h0000;
    localparam logic [VW-1:0] DLY_RST  = 16'h0000;
    localparam logic [VW-1:0] RXTO_RST = 16'h0000;
    localparam logic [SW-1:0] SPN_RST  = 19'h00000;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_LOAD = 2'b01,
        S_SEND = 2'b11
    } dm1_state_t;

    function automatic logic fmi_valid(input logic [FW-1:0] f);
        return (f <= 5'h15) || (f == 5'h1f);
    endfunction

    function automatic logic [FW-1:0] fmi_report(input logic [FW-1:0] f, input logic hi);
        logic [FW-1:0] r;
        r = f;
        if (hi) begin
            case (f)
                5'h01:   r = 5'h00;
                5'h04:   r = 5'h03;
                5'h05:   r = 5'h06;
                5'h11:   r = 5'h0f;
                5'h12:   r = 5'h10;
                5'h15:   r = 5'h14;
                default: r = f;
            endcase
        end
        return r;
    endfunction
endpackage

// ===== dm1_sink.sv
// Model of the CAN side that takes DM1 snapshots from the reporter.
// Assumes dm1_req holds until it is acknowledged on clk.
`timescale 1ns/1ps
module dm1_sink (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic slow,
    input  wire logic dm1_req,
    output logic      dm1_ack
);
    logic [2:0] wait_r;
    // A slow sink holds the ack back so that dm1_req must stand
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_r  <= 3'h0;
            dm1_ack <= 1'b0;
        end else if (dm1_req && !dm1_ack && (!slow || wait_r == 3'h5)) begin
            dm1_ack <= 1'b1;
            wait_r  <= 3'h0;
        end else begin
            dm1_ack <= 1'b0;
            wait_r  <= (dm1_req && !dm1_ack) ? wait_r + 3'h1 : 3'h0;
        end
    end
endmodule

// ===== tb.sv
// Self-checking bench for the fault diagnostic reporter.
// Assumes the DM1 sink model and a 1 ms tick shortened to 10 cycles.
`timescale 1ns/1ps
module tb;
    import fdr_pkg::*;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, rx_seen = 0, nv_load = 0;
    logic [1:0]  nv_load_idx = '0;
    logic [OW-1:0] nv_load_count = '0;
    logic [8:0]  nv_last = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, er, dm1_req, dm1_ack, dm1_multi, nv_store;
    logic [VW-1:0] sample_value [NB] = '{16'h0800, 16'h0200, 16'h0000, 16'h0000};
    logic [2:0]  dm1_count;
    logic [NB-1:0] dm1_mask;
    logic [7:0]  dm1_lamp;
    logic [1:0]  dtc_sel = 2'h0, nv_store_idx;
    logic [SW-1:0] dtc_spn;
    logic [FW-1:0] dtc_fmi;
    logic [OW-1:0] dtc_oc, nv_store_count;
    logic [15:0] notes [$];
    int fails = 0, check_count = 0;
    fault_diagnostic_reporter #(.TICK_CYCLES(10)) uut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_value(sample_value), .rx_seen(rx_seen),
        .dm1_ack(dm1_ack), .dm1_req(dm1_req), .dm1_multi(dm1_multi), .dm1_count(dm1_count),
        .dm1_mask(dm1_mask), .dm1_lamp(dm1_lamp), .dtc_sel(dtc_sel), .dtc_spn(dtc_spn),
        .dtc_fmi(dtc_fmi), .dtc_oc(dtc_oc), .nv_load(nv_load), .nv_load_idx(nv_load_idx),
        .nv_load_count(nv_load_count), .nv_store(nv_store), .nv_store_idx(nv_store_idx),
        .nv_store_count(nv_store_count));
    dm1_sink sink (.clk(clk), .resetn(resetn), .slow(slow), .dm1_req(dm1_req), .dm1_ack(dm1_ack));
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // Each accepted DM1 is matched against the oldest expected snapshot
    always @(posedge clk) begin
        if (dm1_req === 1'b1 && dm1_ack === 1'b1) begin
            if (notes.size() == 0) chk(1, 0, "unexpected DM1");
            else chk({dm1_mask, dm1_count, dm1_multi, dm1_lamp}, notes.pop_front(), "DM1 content");
        end
    end
    // Last count handed to storage, checked after the scenario that changes it
    always @(posedge clk) begin
        if (nv_store === 1'b1) nv_last <= {nv_store_idx, nv_store_count};
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic dm1(input logic [15:0] n, input int lim);
        notes.push_back(n);
        for (int i = 0; i < lim && notes.size() != 0; i++) @(posedge clk);
        chk(notes.size(), 0, "DM1 missing");
    endtask
    task automatic dtc(input logic [1:0] s, input logic [30:0] exp);
        dtc_sel <= s;
        repeat (2) @(posedge clk);
        chk({dtc_spn, dtc_fmi, dtc_oc}, exp, "DTC fields");
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h4d3a));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, 12'h040, 0); chk(rd, 32'h14, "block0 cfg reset");
        apb(0, 12'h0ff, 0); chk(er, 1, "unmapped refused");
        apb(1, 12'h044, 5); apb(1, 12'h04c, 16'h1000); apb(1, 12'h050, 16'h10); apb(1, 12'h054, 3);
        apb(1, 12'h040, 32'h19);
        sample_value[0] <= 16'h2000;
        repeat (10) @(posedge clk);
        sample_value[0] <= 16'($urandom_range(16'h0800, 16'h0fe0));
        repeat (60) @(posedge clk);
        sample_value[0] <= 16'h2000;
        dm1({4'h1, 3'h1, 1'b0, 8'h10}, 200);
        dtc(0, {19'h5, 5'h00, 7'h01});
        chk(nv_last, {2'h0, 7'h01}, "count persisted");
        sample_value[0] <= 16'h0ff8;
        repeat (40) @(posedge clk);
        apb(0, 12'h058, 0); chk(rd[0], 1, "flag held in band");
        sample_value[0] <= 16'h0fef;
        dm1({4'h0, 3'h0, 1'b0, 8'h00}, 200);
        apb(0, 12'h058, 0); chk(rd[3:0], 4'ha, "previously active");
        apb(1, 12'h064, 7); apb(1, 12'h068, 16'h0100); apb(1, 12'h060, 32'h47);
        slow <= 1'b1;
        sample_value[0] <= 16'h2000;
        sample_value[1] <= 16'($urandom_range(0, 16'h00ff));
        notes.push_back({4'h2, 3'h1, 1'b0, 8'h04});
        dm1({4'h3, 3'h2, 1'b1, 8'h14}, 300);
        dtc(1, {19'h7, 5'h04, 7'h01});
        dtc(0, {19'h5, 5'h00, 7'h02});
        sample_value[1] <= 16'h0200;
        repeat (40) @(posedge clk);
        sample_value[0] <= 16'h0800;
        apb(0, 12'h078, 0); chk(rd[5:0], 6'h24, "latched code kept");
        apb(1, 12'h000, 1);
        dm1({4'h0, 3'h0, 1'b0, 8'h00}, 200);
        apb(1, 12'h044, 9);
        dtc(0, {19'h9, 5'h00, 7'h00});
        apb(1, 12'h0a0, 32'h160); apb(0, 12'h0a0, 0); chk(rd, 32'h130, "bad failure mode kept");
        nv_load <= 1'b1; nv_load_idx <= 2'h3; nv_load_count <= 7'h2a;
        @(posedge clk);
        nv_load <= 1'b0;
        dtc(3, {19'h0, 5'h13, 7'h2a});
        apb(1, 12'h004, 2);
        repeat (4) @(posedge clk);
        apb(0, 12'h0b8, 0); chk(rd[0], 1, "lost communication");
        rx_seen <= 1'b1;
        @(posedge clk);
        rx_seen <= 1'b0;
        repeat (3) @(posedge clk);
        apb(0, 12'h0b8, 0); chk(rd[0], 0, "receive clears loss");
        apb(1, 12'h08c, 16'h0100); apb(1, 12'h080, 32'h05);
        sample_value[2] <= 16'h0101 + 16'($urandom_range(0, 255));
        slow <= 1'b0;
        dm1({4'h0, 3'h0, 1'b0, 8'h00}, 12000);
        report_and_stop;
    end
endmodule
